// ===== rtl/rcmc_pkg.sv
// Behaviour
// - Command compressor frequency from thermostat judgment.
// - Remote setpoint is base; internal setpoint continuous.
// - Cooling: diff below -1.5C three minutes, off.
// - Dry: diff below -2.0C three minutes, off.
// - Heating: diff above +2.0C three minutes, off.
// - Restart after three minutes and diff recovers.
// - Sub-bottom fan thirty seconds before judgment.
// - Auto mode judgment repeats every ten minutes.
// - First judgment: cool, dry or heat thresholds.
// - Later judgments: hysteresis, dry stays dry unless diff below -2.0C.
// - Fan mode: indoor fan only, no compressor.
// - Five manual fan speeds, super top heating.
// - Fan feedback update every second after start.
// - Speed out of range ten seconds: count, restart.
// - Seven faults latch fault code, stop all except outdoor fan run-on.
// - Outdoor fan with compressor, stops thirty seconds later.
// - Auto vertical swing ranges, none fan stopped.
// - Heating auto vertical angles by zone.
// - Manual vertical positions angle tables.
// - Remote stop closes vertical vanes.
// - Auto horizontal swing, heating zone B fixed ninety.
// - Manual horizontal patterns angle table.
package rcmc_pkg;
    // Temperatures in signed tenths of a degree C
    localparam logic signed [11:0] COOL_OFF_DT     = -12'sd15;
    localparam logic signed [11:0] DRY_OFF_DT      = -12'sd20;
    localparam logic signed [11:0] HEAT_OFF_DT     = 12'sd20;
    localparam logic signed [11:0] AUTO_FIRST_HI   = 12'sd20;
    localparam logic signed [11:0] AUTO_LATER_HI   = 12'sd30;
    localparam logic signed [11:0] AUTO_LO         = -12'sd20;
    localparam int              CLK_HZ          = 250_000_000;
    localparam int              THERMO_MIN      = 3;
    localparam int              THERMO_SEC      = THERMO_MIN * 60;
    localparam int              SAMPLE_SEC      = 30;
    localparam int              JUDGE_MIN       = 10;
    localparam int              JUDGE_SEC       = JUDGE_MIN * 60;
    localparam int              FAN_FAULT_SEC   = 10;
    localparam int              ODFAN_OFF_SEC   = 30;
    localparam logic [11:0]     RPM_HIGH        = 12'd2550;
    localparam logic [11:0]     RPM_LOW         = 12'd50;
    localparam logic [2:0]      FAULT_LIMIT     = 3'd7;
    localparam logic [3:0]      ODFAN_STEPS     = 4'd15;
    // Angles in half degrees
    localparam logic [7:0]      VANE_CLOSED     = 8'h00;
    localparam logic [7:0]      HSWING_MIN      = 8'd130;
    localparam logic [7:0]      HSWING_MAX      = 8'd230;
    localparam logic [7:0]      HFIXED          = 8'd180;
    localparam logic [7:0]      VU_SWING_MIN    = 8'd90;
    localparam logic [7:0]      VU_SWING_MAX    = 8'd140;
    localparam logic [7:0]      VL_SWING_MIN    = 8'd4;
    localparam logic [7:0]      VL_SWING_MAX    = 8'd78;
    localparam logic [7:0]      VU_ZONE_AC      = 8'd50;
    localparam logic [7:0]      VL_ZONE_AC      = 8'd34;
    localparam logic [7:0]      VU_ZONE_B       = 8'd110;
    localparam logic [7:0]      VL_ZONE_B       = 8'd74;

    typedef enum logic [2:0] {RCMC_FAN_ONLY, RCMC_COOL, RCMC_DRY, RCMC_HEAT, RCMC_AUTO} rcmc_mode_e;
    typedef enum logic [2:0] {
        FAN_SPEED_OFF, FAN_SPEED_SUB_BOTTOM, FAN_SPEED_BOTTOM, FAN_SPEED_MID_MINUS,
        FAN_SPEED_MID, FAN_SPEED_MID_PLUS, FAN_SPEED_UPPER, FAN_SPEED_SUPER_TOP
    } rcmc_fan_e;
    typedef enum logic [1:0] {RCMC_ZONE_A, RCMC_ZONE_B, RCMC_ZONE_C} rcmc_zone_e;

    typedef struct packed {
        logic              power_on;
        rcmc_mode_e        mode;
        logic signed [11:0] set_temp;
        logic [2:0]        fan_sel;
        logic              fan_auto;
        logic              vert_auto;
        logic [2:0]        vert_pos;
        logic              horz_auto;
        logic [2:0]        horz_pos;
        logic              summer_house;
    } rcmc_remote_s;

    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
        logic [7:0] horiz;
        logic       swing_v;
        logic       swing_h;
    } rcmc_vane_s;
endpackage : rcmc_pkg

// ===== rtl/rcmc_top.sv
`timescale 1ns/1ps
module rcmc_top #(
    parameter int TICK_CYCLES = rcmc_pkg::CLK_HZ
) (
    input  wire logic                        CLK,
    input  wire logic                        RST_B,
    input  wire rcmc_pkg::rcmc_remote_s      REMOTE,
    input  wire logic signed [11:0]          INTAKE_TEMP,
    input  wire logic signed [11:0]          SHIFT_OFFSET,
    input  wire rcmc_pkg::rcmc_zone_e        HX_ZONE,
    input  wire logic [11:0]                 FAN_RPM,
    input  wire logic [7:0]                  FREQ_DEMAND,
    input  wire logic [3:0]                  ODFAN_DEMAND,
    output logic [7:0]                       COMP_FREQ,
    output logic                             COMP_ON,
    output rcmc_pkg::rcmc_fan_e              FAN_SPEED,
    output logic                             FAN_UPDATE,
    output logic [3:0]                       ODFAN_STEP,
    output rcmc_pkg::rcmc_mode_e             ACTIVE_MODE,
    output rcmc_pkg::rcmc_vane_s             VANE,
    output logic                             FAN_MOTOR_FAULT_CODE
);
    import rcmc_pkg::*;

    // Tick counter needs at least one idle cycle between ticks
    if (TICK_CYCLES < 2) begin : g_tick_check
        $error("TICK_CYCLES too small");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release and one-second tick
    logic        rst_s1_reg;
    logic        rst_b_reg;
    logic [31:0] tick_cnt_reg;
    logic        tick_reg;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_reg <= 1'b0;
            rst_b_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_b_reg  <= rst_s1_reg;
        end
    end
    wire tick_wrap = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
    always_ff @(posedge CLK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            tick_cnt_reg <= 32'h0;
            tick_reg     <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_wrap ? 32'h0 : tick_cnt_reg + 32'h1;
            tick_reg     <= tick_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal setpoint and temperature difference
    wire               running    = REMOTE.power_on && !FAN_MOTOR_FAULT_CODE;
    wire signed [11:0] int_set    = REMOTE.set_temp + SHIFT_OFFSET;
    wire signed [11:0] diff_int   = INTAKE_TEMP - int_set;
    wire signed [11:0] diff_rem   = INTAKE_TEMP - REMOTE.set_temp;

    ////////////////////////////////////////////////////////////////////////
    // Automatic mode judgment
    typedef enum logic [1:0] {AJ_IDLE, AJ_SAMPLE, AJ_RUN} rcmc_aj_e;
    rcmc_aj_e    aj_reg;
    logic [9:0]  aj_cnt_reg;
    logic        aj_first_reg;
    rcmc_mode_e  auto_mode_reg;
    wire         auto_sel    = running && (REMOTE.mode == RCMC_AUTO);
    wire         sample_done = tick_reg && (aj_cnt_reg == 10'(SAMPLE_SEC - 1));
    wire         period_done = tick_reg && (aj_cnt_reg == 10'(JUDGE_SEC - SAMPLE_SEC - 1));

    function automatic rcmc_mode_e judge(input logic signed [11:0] d, input logic first, input rcmc_mode_e prev);
        if (first) begin
            if (d >= AUTO_FIRST_HI) judge = RCMC_COOL;
            else if (d >= AUTO_LO)  judge = RCMC_DRY;
            else                    judge = RCMC_HEAT;
        end else begin
            if (d >= AUTO_LATER_HI) judge = (prev == RCMC_DRY) ? RCMC_DRY : RCMC_COOL;
            else if (d >= AUTO_LO)  judge = prev;
            else                    judge = RCMC_HEAT;
        end
    endfunction : judge

    always_ff @(posedge CLK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            aj_reg        <= AJ_IDLE;
            aj_cnt_reg    <= 10'h0;
            aj_first_reg  <= 1'b1;
            auto_mode_reg <= RCMC_COOL;
        end else if (!auto_sel) begin
            aj_reg       <= AJ_IDLE;
            aj_cnt_reg   <= 10'h0;
            aj_first_reg <= 1'b1;
        end else begin
            case (aj_reg)
                AJ_IDLE: begin
                    aj_reg     <= AJ_SAMPLE;
                    aj_cnt_reg <= 10'h0;
                end
                AJ_SAMPLE: begin
                    if (sample_done) begin
                        auto_mode_reg <= judge(diff_rem, aj_first_reg, auto_mode_reg);
                        aj_first_reg  <= 1'b0;
                        aj_reg        <= AJ_RUN;
                        aj_cnt_reg    <= 10'h0;
                    end else if (tick_reg) aj_cnt_reg <= aj_cnt_reg + 10'h1;
                end
                AJ_RUN: begin
                    if (period_done) begin
                        aj_reg     <= AJ_SAMPLE;
                        aj_cnt_reg <= 10'h0;
                    end else if (tick_reg) aj_cnt_reg <= aj_cnt_reg + 10'h1;
                end
                default: aj_reg <= AJ_IDLE;
            endcase
        end
    end
    wire        sampling = auto_sel && (aj_reg != AJ_RUN);
    rcmc_mode_e eff_mode;
    assign eff_mode = (REMOTE.mode == RCMC_AUTO) ? auto_mode_reg : REMOTE.mode;

    ////////////////////////////////////////////////////////////////////////
    // Thermostat
    logic       comp_on_reg;
    logic [7:0] th_cnt_reg;
    wire off_cond = (eff_mode == RCMC_COOL && diff_int < COOL_OFF_DT)
                 || (eff_mode == RCMC_DRY  && diff_int < DRY_OFF_DT)
                 || (eff_mode == RCMC_HEAT && diff_int > HEAT_OFF_DT);
    wire on_cond  = (eff_mode == RCMC_COOL && diff_int > COOL_OFF_DT)
                 || (eff_mode == RCMC_DRY  && diff_int > DRY_OFF_DT)
                 || (eff_mode == RCMC_HEAT && diff_int < HEAT_OFF_DT);
    wire thermo_ok = running && !sampling && (eff_mode != RCMC_FAN_ONLY);
    wire th_done   = (th_cnt_reg >= 8'(THERMO_SEC));
    wire th_want   = comp_on_reg ? off_cond : 1'b1;
    always_ff @(posedge CLK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            comp_on_reg <= 1'b0;
            th_cnt_reg  <= 8'h0;
        end else if (!thermo_ok) begin
            comp_on_reg <= 1'b0;
            th_cnt_reg  <= 8'(THERMO_SEC);
        end else if (comp_on_reg && !off_cond) begin
            th_cnt_reg  <= 8'h0;
        end else if (comp_on_reg && th_done) begin
            comp_on_reg <= 1'b0;
            th_cnt_reg  <= 8'h0;
        end else if (!comp_on_reg && th_done && on_cond) begin
            comp_on_reg <= 1'b1;
            th_cnt_reg  <= 8'h0;
        end else if (tick_reg && th_want && !th_done) begin
            th_cnt_reg  <= th_cnt_reg + 8'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indoor fan supervision
    logic [2:0] fault_cnt_reg;
    logic [3:0] bad_cnt_reg;
    logic       fan_restart_reg;
    logic       fault_reg;
    wire        fan_want = running && !fan_restart_reg;
    wire        rpm_bad  = (FAN_RPM >= RPM_HIGH) || (FAN_RPM < RPM_LOW);
    wire        bad_done = tick_reg && (bad_cnt_reg == 4'(FAN_FAULT_SEC - 1));
    always_ff @(posedge CLK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            fault_cnt_reg   <= 3'h0;
            bad_cnt_reg     <= 4'h0;
            fan_restart_reg <= 1'b0;
            fault_reg       <= 1'b0;
        end else begin
            fan_restart_reg <= 1'b0;
            if (!fan_want || !rpm_bad) bad_cnt_reg <= 4'h0;
            else if (bad_done) begin
                bad_cnt_reg     <= 4'h0;
                fan_restart_reg <= 1'b1;
                fault_cnt_reg   <= fault_cnt_reg + 3'h1;
                if (fault_cnt_reg == FAULT_LIMIT - 3'h1) fault_reg <= 1'b1;
            end else if (tick_reg) bad_cnt_reg <= bad_cnt_reg + 4'h1;
        end
    end

    rcmc_fan_e fan_next;
    wire heat_now = (eff_mode == RCMC_HEAT);
    assign fan_next = !fan_want              ? FAN_SPEED_OFF :
                      sampling               ? FAN_SPEED_SUB_BOTTOM :
                      REMOTE.fan_auto        ? FAN_SPEED_MID :
                      (REMOTE.fan_sel == 3'd0) ? (heat_now ? FAN_SPEED_SUPER_TOP : FAN_SPEED_UPPER) :
                      (REMOTE.fan_sel == 3'd1) ? FAN_SPEED_MID_PLUS :
                      (REMOTE.fan_sel == 3'd2) ? FAN_SPEED_MID :
                      (REMOTE.fan_sel == 3'd3) ? FAN_SPEED_MID_MINUS : FAN_SPEED_BOTTOM;

    ////////////////////////////////////////////////////////////////////////
    // Outdoor fan run-on
    logic [4:0] od_cnt_reg;
    wire od_run = comp_on_reg || (od_cnt_reg != 5'h0);
    always_ff @(posedge CLK or negedge rst_b_reg) begin
        if (!rst_b_reg) od_cnt_reg <= 5'h0;
        else if (comp_on_reg) od_cnt_reg <= 5'(ODFAN_OFF_SEC);
        else if (tick_reg && od_cnt_reg != 5'h0) od_cnt_reg <= od_cnt_reg - 5'h1;
    end
    wire [3:0] od_step = (ODFAN_DEMAND > ODFAN_STEPS) ? ODFAN_STEPS :
                         (ODFAN_DEMAND == 4'h0) ? 4'h1 : ODFAN_DEMAND;

    ////////////////////////////////////////////////////////////////////////
    // Vanes, half-degree units
    function automatic logic [7:0] vtab(input logic [2:0] p, input logic heat, input logic up);
        logic [7:0] r;
        r = 8'h0;
        case ({heat, up, p})
            5'b01001: r = 8'd40;
            5'b01010: r = 8'd50;
            5'b01011: r = 8'd100;
            5'b01100: r = 8'd110;
            5'b01101: r = 8'd140;
            5'b00001: r = 8'd4;
            5'b00010: r = 8'd14;
            5'b00011: r = 8'd34;
            5'b00100: r = 8'd54;
            5'b00101: r = 8'd78;
            5'b11001: r = 8'd40;
            5'b11010: r = 8'd90;
            5'b11011: r = 8'd110;
            5'b11100: r = 8'd130;
            5'b11101: r = 8'd140;
            5'b10001: r = 8'd34;
            5'b10010: r = 8'd54;
            5'b10011: r = 8'd74;
            5'b10100: r = 8'd94;
            5'b10101: r = 8'd112;
            default:  r = 8'h0;
        endcase
        vtab = r;
    endfunction : vtab

    wire        fan_turn = fan_want && running;
    wire        zone_b   = REMOTE.summer_house || (HX_ZONE == RCMC_ZONE_B);
    wire [7:0]  h_man    = (REMOTE.horz_pos == 3'd2) ? 8'd130 :
                           (REMOTE.horz_pos == 3'd3) ? 8'd155 :
                           (REMOTE.horz_pos == 3'd4) ? 8'd205 :
                           (REMOTE.horz_pos == 3'd5) ? 8'd230 : 8'd180;
    rcmc_vane_s vane_next;
    always_comb begin
        vane_next = '{VANE_CLOSED, VANE_CLOSED, HFIXED, 1'b0, 1'b0};
        if (REMOTE.power_on && !FAN_MOTOR_FAULT_CODE) begin
            if (!REMOTE.vert_auto) begin
                vane_next.upper = vtab(REMOTE.vert_pos, heat_now, 1'b1);
                vane_next.lower = vtab(REMOTE.vert_pos, heat_now, 1'b0);
            end else if (heat_now) begin
                vane_next.upper = zone_b ? VU_ZONE_B : VU_ZONE_AC;
                vane_next.lower = zone_b ? VL_ZONE_B : VL_ZONE_AC;
            end else begin
                vane_next.upper   = VU_SWING_MIN;
                vane_next.lower   = VL_SWING_MIN;
                vane_next.swing_v = fan_turn;
            end
            if (!REMOTE.horz_auto) vane_next.horiz = h_man;
            else if (!(heat_now && HX_ZONE == RCMC_ZONE_B)) begin
                vane_next.horiz   = HSWING_MIN;
                vane_next.swing_h = fan_turn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge CLK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            COMP_FREQ            <= 8'h0;
            COMP_ON              <= 1'b0;
            FAN_SPEED            <= FAN_SPEED_OFF;
            FAN_UPDATE           <= 1'b0;
            ODFAN_STEP           <= 4'h0;
            ACTIVE_MODE          <= RCMC_FAN_ONLY;
            VANE                 <= '{VANE_CLOSED, VANE_CLOSED, HFIXED, 1'b0, 1'b0};
            FAN_MOTOR_FAULT_CODE <= 1'b0;
        end else begin
            COMP_FREQ            <= comp_on_reg ? FREQ_DEMAND : 8'h0;
            COMP_ON              <= comp_on_reg;
            FAN_SPEED            <= fan_next;
            FAN_UPDATE           <= tick_reg && fan_want;
            ODFAN_STEP           <= od_run ? od_step : 4'h0;
            ACTIVE_MODE          <= eff_mode;
            VANE                 <= vane_next;
            FAN_MOTOR_FAULT_CODE <= FAN_MOTOR_FAULT_CODE || fault_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_fan_only_comp: assert property (@(posedge CLK) disable iff (!rst_b_reg)
        (REMOTE.mode == RCMC_FAN_ONLY) |=> ##1 !COMP_ON) else $error("compressor on in fan mode");
    a_fault_stop: assert property (@(posedge CLK) disable iff (!rst_b_reg)
        FAN_MOTOR_FAULT_CODE |=> ##1 (FAN_SPEED == FAN_SPEED_OFF && !COMP_ON)) else $error("run after fault");
    a_fault_sticky: assert property (@(posedge CLK) disable iff (!rst_b_reg)
        FAN_MOTOR_FAULT_CODE |=> FAN_MOTOR_FAULT_CODE) else $error("fault cleared");
    a_odfan_with_comp: assert property (@(posedge CLK) disable iff (!rst_b_reg)
        COMP_ON |-> ODFAN_STEP != 4'h0) else $error("outdoor fan stopped while compressor on");
    a_comp_freq_off: assert property (@(posedge CLK) disable iff (!rst_b_reg)
        !COMP_ON |-> COMP_FREQ == 8'h0) else $error("frequency without compressor");
    a_sample_speed: assert property (@(posedge CLK) disable iff (!rst_b_reg)
        (sampling && fan_want) |=> FAN_SPEED == FAN_SPEED_SUB_BOTTOM) else $error("sample speed wrong");
    a_vane_closed: assert property (@(posedge CLK) disable iff (!rst_b_reg)
        !REMOTE.power_on |=> (VANE.upper == VANE_CLOSED && VANE.lower == VANE_CLOSED)) else $error("vane open");
    a_no_swing_stop: assert property (@(posedge CLK) disable iff (!rst_b_reg)
        !fan_turn |=> (!VANE.swing_v && !VANE.swing_h)) else $error("swing with fan stopped");
    a_restart_wait: assert property (@(posedge CLK) disable iff (!rst_b_reg)
        $fell(comp_on_reg) && $past(thermo_ok) && thermo_ok |-> th_cnt_reg == 8'h0)
        else $error("restart wait not started");
    c_comp_on:    cover property (@(posedge CLK) $rose(COMP_ON));
    c_thermo_off: cover property (@(posedge CLK) $fell(comp_on_reg) && thermo_ok);
    c_fan_fault:  cover property (@(posedge CLK) $rose(FAN_MOTOR_FAULT_CODE));
    c_auto_heat:  cover property (@(posedge CLK) auto_sel && auto_mode_reg == RCMC_HEAT);
endmodule : rcmc_top

// ===== tb/rcmc_far_side.sv
`timescale 1ns/1ps
module rcmc_far_side
    import rcmc_pkg::*;
(
    input  wire rcmc_pkg::rcmc_fan_e fan_speed,
    input  wire logic                stall,
    output logic [11:0]              rpm
);
    // A stalled or stopped motor reads zero, never its last good speed
    assign rpm = (fan_speed == FAN_SPEED_OFF || stall) ? 12'h000 : 12'h200 + {2'h0, fan_speed, 7'h00};
endmodule : rcmc_far_side

// ===== tb/tb_room_climate_mode_controller.sv
`timescale 1ns/1ps
module tb_room_climate_mode_controller;
    import rcmc_pkg::*;
    localparam int T = 4;
    logic CLK = 1'b0, RST_B = 1'b0, stall = 1'b0, COMP_ON, FAN_UPDATE, FAN_MOTOR_FAULT_CODE;
    rcmc_remote_s REMOTE = '0;
    logic signed [11:0] INTAKE_TEMP = 12'sd250, SHIFT_OFFSET = 12'sd0;
    rcmc_zone_e HX_ZONE = RCMC_ZONE_A;
    logic [11:0] FAN_RPM, q_e;
    logic [7:0] FREQ_DEMAND = 8'h40, COMP_FREQ;
    logic [3:0] ODFAN_DEMAND = 4'h5, ODFAN_STEP;
    rcmc_fan_e FAN_SPEED;
    rcmc_mode_e ACTIVE_MODE;
    rcmc_vane_s VANE;
    int fail_count = 0, comparisons = 0, seed = 61, upd_cnt = 0, upd_base = 0, q_i;
    int qid[$];
    logic [11:0] qexp[$];
    event chk_ev;
    logic [7:0] vu[10] = '{8'd40, 8'd50, 8'd100, 8'd110, 8'd140, 8'd40, 8'd90, 8'd110, 8'd130, 8'd140};
    logic [7:0] vl[10] = '{8'd4, 8'd14, 8'd34, 8'd54, 8'd78, 8'd34, 8'd54, 8'd74, 8'd94, 8'd112};
    logic [7:0] hz[5] = '{8'd180, 8'd130, 8'd155, 8'd205, 8'd230};
    string nm[11] = '{"comp_on", "fan_speed", "odfan", "mode", "upper", "lower", "horiz", "fault", "freq",
                      "updates", "swing"};

    always #2 CLK = ~CLK;
    always @(posedge CLK) if (FAN_UPDATE === 1'b1) upd_cnt <= upd_cnt + 1;

    rcmc_top #(.TICK_CYCLES(T)) dut_u (.CLK, .RST_B, .REMOTE, .INTAKE_TEMP, .SHIFT_OFFSET, .HX_ZONE, .FAN_RPM,
        .FREQ_DEMAND, .ODFAN_DEMAND, .COMP_FREQ, .COMP_ON, .FAN_SPEED, .FAN_UPDATE, .ODFAN_STEP, .ACTIVE_MODE,
        .VANE, .FAN_MOTOR_FAULT_CODE);
    rcmc_far_side far_u (.fan_speed(FAN_SPEED), .stall(stall), .rpm(FAN_RPM));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] seen(input int id);
        case (id)
            0: return 12'(COMP_ON);
            1: return 12'(FAN_SPEED);
            2: return 12'(ODFAN_STEP);
            3: return 12'(ACTIVE_MODE);
            4: return 12'(VANE.upper);
            5: return 12'(VANE.lower);
            6: return 12'(VANE.horiz);
            7: return 12'(FAN_MOTOR_FAULT_CODE);
            8: return 12'(COMP_FREQ);
            10: return 12'({VANE.swing_v, VANE.swing_h});
            default: return 12'(upd_cnt - upd_base);
        endcase
    endfunction : seen

    // Checker drains every note queued in this time step
    always @(chk_ev) begin
        while (qid.size() > 0) begin
            q_i = qid.pop_front();
            q_e = qexp.pop_front();
            comparisons++;
            if (seen(q_i) !== q_e) begin
                fail_count++;
                $display("ERROR %s expected %0h seen %0h", nm[q_i], q_e, seen(q_i));
            end
        end
    end

    task automatic chk(input int id, input logic [11:0] e);
        qid.push_back(id);
        qexp.push_back(e);
        ->chk_ev;
    endtask : chk

    task automatic cyc(input int c);
        repeat (c) @(negedge CLK);
    endtask : cyc

    task automatic run(input rcmc_mode_e m, input logic signed [11:0] d);
        REMOTE.power_on = 1'b0;
        cyc(4);
        chk(4, 12'(VANE_CLOSED));
        REMOTE.mode = m;
        INTAKE_TEMP = REMOTE.set_temp + d;
        REMOTE.power_on = 1'b1;
        cyc(2 * T);
    endtask : run

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        fail_count++;
        test_done;
    end

    initial begin
        cyc(2);
        RST_B = 1'b1;
        cyc(3);
        chk(0, 12'h000);
        chk(6, 12'(HFIXED));
        REMOTE.set_temp = 12'sd250;
        FREQ_DEMAND = 8'($random(seed));
        ODFAN_DEMAND = 4'($random(seed)) | 4'h1;
        run(RCMC_COOL, 12'sd0);
        chk(0, 12'h001);
        chk(8, 12'(FREQ_DEMAND));
        chk(2, 12'(ODFAN_DEMAND));
        // Brief lapse must restart the persistence count
        INTAKE_TEMP = 12'sd234;
        cyc(170 * T);
        INTAKE_TEMP = 12'sd235;
        cyc(2 * T);
        INTAKE_TEMP = 12'sd234;
        cyc(175 * T);
        chk(0, 12'h001);
        cyc(10 * T);
        chk(0, 12'h000);
        cyc(20 * T);
        chk(2, 12'(ODFAN_DEMAND));
        cyc(10 * T);
        chk(2, 12'h000);
        INTAKE_TEMP = 12'sd250;
        cyc(135 * T);
        chk(0, 12'h000);
        cyc(20 * T);
        chk(0, 12'h001);
        // Offset moves the internal setpoint, intake stays put
        for (int i = 0; i < 2; i++) begin
            run(i ? RCMC_HEAT : RCMC_DRY, 12'sd0);
            SHIFT_OFFSET = i ? -12'sd21 : 12'sd21;
            cyc(175 * T);
            chk(0, 12'h001);
            cyc(10 * T);
            chk(0, 12'h000);
        end
        SHIFT_OFFSET = 12'sd0;
        for (int h = 0; h < 2; h++) begin
            run(h ? RCMC_HEAT : RCMC_COOL, 12'sd0);
            upd_base = upd_cnt;
            cyc(40);
            chk(9, 12'd10);
            for (int p = 0; p < 5; p++) begin
                REMOTE.fan_sel = 3'(p);
                REMOTE.vert_pos = 3'(p + 1);
                REMOTE.horz_pos = 3'(p + 1);
                cyc(4);
                chk(1, p ? 12'(6 - p) : 12'(h ? FAN_SPEED_SUPER_TOP : FAN_SPEED_UPPER));
                chk(4, 12'(vu[h * 5 + p]));
                chk(5, 12'(vl[h * 5 + p]));
                chk(6, 12'(hz[p]));
            end
        end
        REMOTE.vert_auto = 1'b1;
        REMOTE.horz_auto = 1'b1;
        for (int z = 0; z < 4; z++) begin
            HX_ZONE = rcmc_zone_e'(z % 3);
            REMOTE.summer_house = (z == 3);
            cyc(4);
            chk(4, (z % 2) ? 12'(VU_ZONE_B) : 12'(VU_ZONE_AC));
            chk(5, (z % 2) ? 12'(VL_ZONE_B) : 12'(VL_ZONE_AC));
            if (z == 1) chk(6, 12'(HFIXED));
        end
        run(RCMC_FAN_ONLY, -12'sd200);
        chk(0, 12'h000);
        chk(2, 12'(ODFAN_DEMAND));
        chk(1, 12'(FAN_SPEED_BOTTOM));
        chk(4, 12'(VU_SWING_MIN));
        chk(5, 12'(VL_SWING_MIN));
        chk(6, 12'(HSWING_MIN));
        chk(10, 12'h003);
        // Outdoor fan run-on from the heating compressor ends first
        cyc(30 * T);
        chk(2, 12'h000);
        run(RCMC_AUTO, -12'sd20);
        cyc(8 * T);
        chk(1, 12'(FAN_SPEED_SUB_BOTTOM));
        chk(0, 12'h000);
        cyc(30 * T);
        chk(3, 12'(RCMC_DRY));
        INTAKE_TEMP = 12'sd280;
        cyc(600 * T);
        chk(3, 12'(RCMC_DRY));
        INTAKE_TEMP = 12'sd229;
        cyc(578 * T);
        chk(3, 12'(RCMC_DRY));
        cyc(20 * T);
        chk(3, 12'(RCMC_HEAT));
        run(RCMC_COOL, 12'sd0);
        stall = 1'b1;
        cyc(15 * T);
        chk(7, 12'h000);
        cyc(120 * T);
        chk(7, 12'h001);
        chk(1, 12'(FAN_SPEED_OFF));
        chk(10, 12'h000);
        stall = 1'b0;
        run(RCMC_COOL, 12'sd0);
        chk(0, 12'h000);
        // Only a reset clears the latched fault
        RST_B = 1'b0;
        cyc(2);
        RST_B = 1'b1;
        cyc(3);
        chk(7, 12'h000);
        run(RCMC_COOL, 12'sd0);
        chk(0, 12'h001);
        cyc(2);
        test_done;
    end
endmodule : tb_room_climate_mode_controller
